/* File: logic/ssc_pkg.sv */
// Package for the serial switch control block
package ssc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int OUT_COUNT = 16;
    localparam int CMD_HI = 23;
    localparam int CMD_LO = 18;
    localparam int OV_RETRY_BIT = 16;
    localparam int STAT_ANY_POS = 23;
    localparam int STAT_OV_POS = 22;
    localparam logic [5:0] CMD_ON_OFF = 6'h00;
    localparam logic [5:0] CMD_GLOBAL_PWM = 6'h04;
    localparam logic [5:0] CMD_SHUTDOWN_RETRY = 6'h07;
    localparam int CLK_MHZ = 50;
    localparam int OV_QUAL_US = 50;
    localparam int OV_QUAL_CYCLES = OV_QUAL_US * CLK_MHZ;
    localparam logic [15:0] DIRECT_MASK = 16'hc3c3;
    localparam logic [23:0] FRAME_RESET = 24'h000000;
    localparam logic [15:0] OUT_RESET = 16'h0000;

    typedef struct packed {
        logic selectN;
        logic clk;
        logic data;
    } ssc_link_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_APPLY = 3'b100
    } ssc_state_t;
endpackage

/* File: logic/ssc_serial_switch.sv */
// Serial control and fault reporting of a sixteen channel low side switch
`timescale 1ns/1ns
module ssc_serial_switch #(
    parameter int OV_QUAL = ssc_pkg::OV_QUAL_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Serial link pins
    input wire logic spiSelectN,
    input wire logic spiClk,
    input wire logic spiIn,
    output logic spiOut,
    output logic spiOutEnN,
    // Supplies and clear
    input wire logic clearN,
    input wire logic serial_out_supply_ok,
    input wire logic load_battery_supply_over,
    // Modulation inputs
    input wire logic [7:0] direct_modulation_inputs,
    input wire logic globalModulation,
    // Filtered per output faults
    input wire logic [15:0] outputFaults,
    // Switch controls
    output logic [15:0] low_side_switch_outputs,
    // Received frames
    output logic [23:0] frameData,
    output logic frameValid,
    input wire logic frameReady
);
    initial begin
        if (OV_QUAL < 1) $error("OV_QUAL must be positive");
        if (ssc_pkg::FRAME_BITS != 24) $error("frame width must be 24 bits");
    end

    // Synchronisers
    logic [1:0] syncSel;
    logic [1:0] syncClk;
    logic [1:0] syncIn;
    logic [1:0] syncClr;
    logic [1:0] syncSup;
    logic [1:0] syncOv;
    logic [1:0] syncGlob;
    logic [7:0] syncDirA;
    logic [7:0] syncDirB;
    logic [1:0] next_syncSel;
    logic [1:0] next_syncClk;
    logic [1:0] next_syncIn;
    logic [1:0] next_syncClr;
    logic [1:0] next_syncSup;
    logic [1:0] next_syncOv;
    logic [1:0] next_syncGlob;
    logic [7:0] next_syncDirA;
    logic [7:0] next_syncDirB;
    logic selD;
    logic clkD;
    logic next_selD;
    logic next_clkD;
    always_comb begin
        next_syncSel = {syncSel[0], spiSelectN};
        next_syncClk = {syncClk[0], spiClk};
        next_syncIn = {syncIn[0], spiIn};
        next_syncClr = {syncClr[0], clearN};
        next_syncSup = {syncSup[0], serial_out_supply_ok};
        next_syncOv = {syncOv[0], load_battery_supply_over};
        next_syncGlob = {syncGlob[0], globalModulation};
        next_syncDirA = direct_modulation_inputs;
        next_syncDirB = syncDirA;
        next_selD = syncSel[1];
        next_clkD = syncClk[1];
    end
    always_ff @(posedge sys_clk) begin
        syncSel <= next_syncSel;
        syncClk <= next_syncClk;
        syncIn <= next_syncIn;
        syncClr <= next_syncClr;
        syncSup <= next_syncSup;
        syncOv <= next_syncOv;
        syncGlob <= next_syncGlob;
        syncDirA <= next_syncDirA;
        syncDirB <= next_syncDirB;
        selD <= next_selD;
        clkD <= next_clkD;
    end

    logic sel;
    logic selFall;
    logic selRise;
    logic clkFall;
    logic clkRise;
    logic softReset;
    always_comb begin
        sel = ~syncSel[1];
        selFall = selD & ~syncSel[1];
        selRise = ~selD & syncSel[1];
        clkFall = clkD & ~syncClk[1] & sel;
        clkRise = ~clkD & syncClk[1] & sel;
        softReset = reset | ~syncClr[1] | ~syncSup[1];
    end

    // Overvoltage qualification
    logic [31:0] ovCount;
    logic [31:0] next_ovCount;
    logic ovShut;
    logic next_ovShut;
    logic ovLatched;
    logic next_ovLatched;
    logic ovRetry;
    logic next_ovRetry;
    always_comb begin
        next_ovCount = ovCount;
        next_ovShut = ovShut;
        next_ovLatched = ovLatched;
        if (syncOv[1]) begin
            if (ovCount < 32'(OV_QUAL)) begin
                next_ovCount = ovCount + 32'h1;
            end else begin
                next_ovShut = 1'b1;
                next_ovLatched = 1'b1;
            end
        end else begin
            next_ovCount = 32'h0;
            next_ovShut = ovShut & ~ovRetry;
        end
        if (selFall && !syncOv[1]) begin
            next_ovLatched = 1'b0;
        end
    end

    // Shifting and framing
    ssc_pkg::ssc_state_t state, next_state;
    logic [23:0] shiftIn;
    logic [23:0] next_shiftIn;
    logic outBit;
    logic next_outBit;
    logic outEnN;
    logic next_outEnN;
    logic [15:0] onOff;
    logic [15:0] next_onOff;
    logic [15:0] pwmSel;
    logic [15:0] next_pwmSel;
    logic [15:0] drive;
    logic [15:0] next_drive;
    logic [23:0] status;
    always_comb begin
        status = {ovLatched | (|outputFaults), ovLatched, 6'h00, outputFaults};
    end

    // Two entry frame buffer
    logic [23:0] bufMem [2];
    logic [23:0] next_buf0;
    logic [23:0] next_buf1;
    logic [1:0] bufCount;
    logic [1:0] next_bufCount;
    logic bufValid;
    logic next_bufValid;
    logic pushReq;
    logic pushOk;
    logic popOk;
    always_comb begin
        next_state = state;
        next_shiftIn = shiftIn;
        next_outBit = outBit;
        next_outEnN = ~sel;
        next_onOff = onOff;
        next_pwmSel = pwmSel;
        next_ovRetry = ovRetry;
        pushReq = 1'b0;
        case (state)
            ssc_pkg::ST_IDLE: begin
                if (selFall) begin
                    next_shiftIn = status;
                    next_outBit = status[23];
                    next_state = ssc_pkg::ST_SHIFT;
                end
            end
            ssc_pkg::ST_SHIFT: begin
                if (clkFall) begin
                    next_shiftIn = {shiftIn[22:0], syncIn[1]};
                end
                if (clkRise) begin
                    next_outBit = shiftIn[22];
                end
                if (selRise) begin
                    next_state = ssc_pkg::ST_APPLY;
                end
            end
            default: begin
                pushReq = 1'b1;
                next_state = ssc_pkg::ST_IDLE;
                case (shiftIn[ssc_pkg::CMD_HI:ssc_pkg::CMD_LO])
                    ssc_pkg::CMD_ON_OFF: next_onOff = shiftIn[15:0];
                    ssc_pkg::CMD_GLOBAL_PWM: next_pwmSel = shiftIn[15:0];
                    ssc_pkg::CMD_SHUTDOWN_RETRY: next_ovRetry = shiftIn[ssc_pkg::OV_RETRY_BIT];
                    default: next_onOff = onOff;
                endcase
            end
        endcase
    end

    always_comb begin
        pushOk = pushReq & (bufCount != 2'h2);
        popOk = (bufCount != 2'h0) & frameReady;
        next_buf0 = bufMem[0];
        next_buf1 = bufMem[1];
        next_bufCount = bufCount;
        if (popOk) begin
            next_buf0 = bufMem[1];
            next_bufCount = next_bufCount - 2'h1;
        end
        if (pushOk) begin
            if (next_bufCount == 2'h0) begin
                next_buf0 = shiftIn;
            end else begin
                next_buf1 = shiftIn;
            end
            next_bufCount = next_bufCount + 2'h1;
        end
        next_bufValid = (next_bufCount != 2'h0);
    end

    // Output drive
    logic [15:0] direct;
    always_comb begin
        direct = {syncDirB[7:6], 4'h0, syncDirB[5:2], 4'h0, syncDirB[1:0]};
        next_drive = (onOff & ~ssc_pkg::DIRECT_MASK) | (direct & onOff & ssc_pkg::DIRECT_MASK);
        next_drive = next_drive & (~pwmSel | {16{syncGlob[1]}});
        if (ovShut) begin
            next_drive = ssc_pkg::OUT_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (softReset) begin
            state <= ssc_pkg::ST_IDLE;
            shiftIn <= ssc_pkg::FRAME_RESET;
            outBit <= 1'b0;
            outEnN <= 1'b1;
            onOff <= ssc_pkg::OUT_RESET;
            pwmSel <= ssc_pkg::OUT_RESET;
            drive <= ssc_pkg::OUT_RESET;
            ovRetry <= 1'b0;
            ovCount <= 32'h0;
            ovShut <= 1'b0;
            ovLatched <= 1'b0;
            bufCount <= 2'h0;
            bufValid <= 1'b0;
            bufMem[0] <= ssc_pkg::FRAME_RESET;
            bufMem[1] <= ssc_pkg::FRAME_RESET;
        end else begin
            state <= next_state;
            shiftIn <= next_shiftIn;
            outBit <= next_outBit;
            outEnN <= next_outEnN;
            onOff <= next_onOff;
            pwmSel <= next_pwmSel;
            drive <= next_drive;
            ovRetry <= next_ovRetry;
            ovCount <= next_ovCount;
            ovShut <= next_ovShut;
            ovLatched <= next_ovLatched;
            bufCount <= next_bufCount;
            bufValid <= next_bufValid;
            bufMem[0] <= next_buf0;
            bufMem[1] <= next_buf1;
        end
    end

    always_comb begin
        spiOut = outBit;
        spiOutEnN = outEnN;
        low_side_switch_outputs = drive;
        frameData = bufMem[0];
        frameValid = bufValid;
    end
endmodule

/* File: test/ssc_checker.sv */
// Assertions on the serial switch ports
`timescale 1ns/1ns
module ssc_checker #(parameter int OV_QUAL = 10) (
    // Watched ports
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic spiSelectN,
    input wire logic spiClk,
    input wire logic spiOut,
    input wire logic spiOutEnN,
    input wire logic clearN,
    input wire logic serial_out_supply_ok,
    input wire logic load_battery_supply_over,
    input wire logic [7:0] direct_modulation_inputs,
    input wire logic [15:0] low_side_switch_outputs,
    input wire logic frameValid,
    input wire logic frameReady,
    input wire logic [23:0] frameData
);
    int ovCount;
    int next_ovCount;
    logic [15:0] outs;
    assign outs = low_side_switch_outputs;
    always_comb next_ovCount = load_battery_supply_over ? ovCount + 1 : 0;
    always_ff @(posedge sys_clk) ovCount <= reset ? 0 : next_ovCount;
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence selHeld; (!spiSelectN && clearN) [*8]; endsequence
    sequence csRise; $rose(spiSelectN) ##1 clearN; endsequence
    a_oe_selected: assert property (selHeld |-> !spiOutEnN) else $error("not driven");
    a_oe_idle: assert property (spiSelectN [*5] |-> spiOutEnN) else $error("driven idle");
    a_out_quiet: assert property ((!spiClk && !spiSelectN) [*8] |-> $stable(spiOut)) else $error("moved");
    a_frame_push: assert property (csRise |-> ##[1:8] frameValid) else $error("no frame");
    a_frame_hold: assert property (frameValid && !frameReady |=> frameValid && $stable(frameData)) else $error("lost");
    a_clear_off: assert property (!clearN [*4] |-> outs == 16'h0000) else $error("clear");
    a_supply_off: assert property (!serial_out_supply_ok [*4] |-> outs == 16'h0000) else $error("supply");
    a_ov_off: assert property (ovCount > OV_QUAL + 6 |-> outs == 16'h0000) else $error("overvoltage");
    a_direct_low: assert property ((direct_modulation_inputs == 8'h00) [*4] |-> (outs & 16'hc3c3) == 16'h0000)
        else $error("direct");
endmodule
bind ssc_serial_switch ssc_checker #(.OV_QUAL(OV_QUAL)) chk (.sys_clk, .reset, .spiSelectN, .spiClk, .spiOut,
    .spiOutEnN, .clearN, .serial_out_supply_ok, .load_battery_supply_over, .direct_modulation_inputs,
    .low_side_switch_outputs, .frameValid, .frameReady, .frameData);

/* File: test/ssc_spi_master.sv */
// Behavioural serial master facing the switch
`timescale 1ns/1ns
module ssc_spi_master (
    // Link to the switch
    output ssc_pkg::ssc_link_t link,
    input wire logic miso
);
    initial link = 3'b100;
    // One selection of n bits, msb first
    task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
        rx = '0;
        link.selectN = 1'b0;
        #160;
        for (int i = n - 1; i >= 0; i--) begin
            #40 link.data = tx[i];
            #40 rx = {rx[46:0], miso};
            link.clk = 1'b1;
            #80 link.clk = 1'b0;
        end
        #80 link.selectN = 1'b1;
        link.data = ~link.data;
    endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the serial switch
`timescale 1ns/1ns
module testbench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clearN = 1'b1;
    logic supplyOk = 1'b1;
    logic over = 1'b0;
    logic [7:0] direct = 8'hff;
    logic globalModulation = 1'b0;
    logic [15:0] faults = 16'h0000;
    logic frameReady = 1'b0;
    logic spiOut;
    logic spiOutEnN;
    logic frameValid;
    logic [15:0] outs;
    logic [23:0] frameData;
    logic [47:0] rx;
    ssc_pkg::ssc_link_t link;
    int n_errors = 0;
    int checks_done = 0;
    ssc_serial_switch #(.OV_QUAL(10)) DUT (.sys_clk, .reset, .spiSelectN(link.selectN), .spiClk(link.clk),
        .spiIn(link.data), .spiOut, .spiOutEnN, .clearN, .serial_out_supply_ok(supplyOk),
        .load_battery_supply_over(over), .direct_modulation_inputs(direct), .globalModulation,
        .outputFaults(faults), .low_side_switch_outputs(outs), .frameData, .frameValid, .frameReady);
    ssc_spi_master master (.link, .miso(spiOut));
    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic send(input logic [5:0] cmd, input logic [17:0] arg);
        master.xfer(24, {24'h0, cmd, arg}, rx);
        cyc(8);
    endtask
    task automatic pop;
        frameReady = 1'b1;
        cyc(1);
        frameReady = 1'b0;
    endtask
    task automatic t_status;
        faults = 16'ha5c3;
        send(6'h00, 18'h0ffff);
        check(rx[23:0], 24'h80a5c3);
        check(outs, 16'hffff);
        check(frameData, 24'h00ffff);
        check(spiOutEnN, 1'b1);
        pop;
        faults = 16'h0000;
    endtask
    task automatic t_modulation;
        int pos[8] = '{0, 1, 6, 7, 8, 9, 14, 15};
        logic [15:0] want;
        direct = 8'h00;
        cyc(4);
        check(outs, 16'h3c3c);
        send(6'h04, 18'h000ff);
        check(outs, 16'h3c00);
        pop;
        globalModulation = 1'b1;
        for (int i = 0; i < 8; i++) begin
            direct = ~(8'h01 << i);
            cyc(4);
            want = ~(16'h0001 << pos[i]);
            check(outs, want);
        end
        direct = 8'hff;
        cyc(4);
        check(outs, 16'hffff);
    endtask
    task automatic t_echo;
        master.xfer(48, 48'h00a5a5_000001, rx);
        cyc(8);
        check(rx[23:0], 24'h00a5a5);
        check(outs, 16'h0001);
        check(frameData, 24'h000001);
        pop;
    endtask
    task automatic t_buffer;
        for (int i = 1; i < 4; i++) send(6'h00, 18'(i));
        check(outs, 16'h0003);
        check(frameData, 24'h000001);
        pop;
        check(frameData, 24'h000002);
        pop;
        check(frameValid, 1'b0);
    endtask
    task automatic t_clear;
        for (int k = 0; k < 2; k++) begin
            send(6'h00, 18'h0ffff);
            pop;
            clearN = k[0];
            supplyOk = !k[0];
            cyc(6);
            check(outs, 16'h0000);
            clearN = 1'b1;
            supplyOk = 1'b1;
            cyc(4);
            check(outs, 16'h0000);
        end
    endtask
    task automatic t_ov;
        for (int k = 1; k >= 0; k--) begin
            send(6'h00, 18'h00003);
            send(6'h07, 18'(k) << 16);
            pop;
            pop;
            over = 1'b1;
            cyc(20);
            check(outs, 16'h0000);
            over = 1'b0;
            cyc(6);
            check(outs, k ? 16'h0003 : 16'h0000);
            send(6'h00, 18'h00003);
            check(rx[23:22], 2'b11);
            pop;
        end
    endtask
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #1500000;
        n_errors++;
        wrap_up;
    end
    initial begin
        cyc(6);
        reset = 1'b0;
        cyc(4);
        t_status;
        t_modulation;
        t_echo;
        t_buffer;
        t_clear;
        t_ov;
        wrap_up;
    end
endmodule
